/* File: hdl/rtcp_ctrl.sv */
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Prescaler divides low-speed clock to 1 Hz.
// - Adjust request waits for next seconds count-up.
// - Adjust at 0-29 seconds clears seconds only.
// - Adjust at 30-59 bumps minutes, clears seconds.
// - Adjust bit reads pending; writing zero ignored.
// - Counter clear request sampled on low-speed clock.
// - Counter clear bit reads one until done.
// - Alarm init loads 00 min, 00 h, 01, Sunday.
// - Rate disables and alarm enable choose interrupt source.
// - Page select steers shared addresses to alarm bank.
// - Run disable stops counting; prescaler keeps going.
module rtcp_ctrl
    import rtcp_pkg::*;
#(
    parameter int DIV = TICK_1HZ_DIV,
    parameter int SUB = TICK_16HZ_DIV
) (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // AXI4-Lite write
    input logic [7:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    // AXI4-Lite read
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    // Low-speed clock level, sampled on aclk
    input logic low_speed_clk,
    // Rest of calendar
    input logic [7:0] cur_hour,
    input logic [7:0] cur_date,
    input logic [2:0] cur_day,
    output logic minute_carry,
    // Events
    output logic rtc_interrupt,
    output logic irq
);
    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [7:0] w_data;
        logic w_en;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic ls_prev;
        logic irq_enable;
        logic adjust_pend;
        logic clock_run_enable;
        logic alarm_enable;
        logic page_sel;
        logic one_hz_disable;
        logic sixteen_hz_disable;
        logic clr_pend;
        logic [2:0] fill;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] al_min;
        logic [7:0] al_hour;
        logic [7:0] al_date;
        logic [2:0] al_day;
        logic [2:0] status;
        logic [2:0] mask;
        logic carry;
        logic src_pulse;
    } rtcp_st_t;

    // Edge history starts high: a pin already high at release gives no false tick
    localparam rtcp_st_t ST_RST = '{ls_prev: 1'b1, one_hz_disable: 1'b1, sixteen_hz_disable: 1'b1,
                                     fill: RS_FILL_RST, default: '0};

    rtcp_st_t r_reg;
    rtcp_st_t r_next;
    logic fs_tick;
    logic tick_1hz;
    logic tick_16hz;
    logic pre_clear;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v == BCD_59) begin
            bcd_inc = 8'h00;
        end else if (v[3:0] == 4'h9) begin
            bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            bcd_inc = {v[7:4], 4'(v[3:0] + 4'h1)};
        end
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_SEC) || (a == OFS_MIN) || (a == OFS_HOUR) || (a == OFS_DATE) ||
                 (a == OFS_DAY) || (a == OFS_PAGE) || (a == OFS_RESET) || (a == OFS_STAT) ||
                 (a == OFS_MASK);
    endfunction

    // ------------------------------------------------------------
    // Second prescaler
    // ------------------------------------------------------------
    // Edge detect is safe without a synchroniser: input taken as synchronous
    assign fs_tick = low_speed_clk & ~r_reg.ls_prev;
    assign pre_clear = fs_tick & r_reg.clr_pend;

    rtcp_prescaler #(
        .DIV(DIV),
        .SUB(SUB)
    ) u_pre (
        .aclk(aclk),
        .aresetn(aresetn),
        .fs_tick(fs_tick),
        .clear(pre_clear),
        .tick_1hz(tick_1hz),
        .tick_16hz(tick_16hz)
    );

    assign s_axi_awready = ~r_reg.aw_full & ~r_reg.bvalid;
    assign s_axi_wready = ~r_reg.w_full & ~r_reg.bvalid;
    assign s_axi_arready = ~r_reg.rvalid;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] ev;
        logic [2:0] w1c;
        logic alarm_hit;
        logic src;
        logic wr;
        logic [7:0] wd;
        ev = '0;
        w1c = '0;
        alarm_hit = 1'b0;
        src = 1'b0;
        wr = 1'b0;
        wd = r_reg.w_data;
        r_next = r_reg;
        r_next.ls_prev = low_speed_clk;
        r_next.carry = 1'b0;
        r_next.src_pulse = 1'b0;

        // Calendar counting, halted by run disable only
        if (tick_1hz && r_reg.clock_run_enable) begin
            if (r_reg.adjust_pend) begin
                r_next.adjust_pend = 1'b0;
                ev[ST_ADJ] = 1'b1;
                r_next.sec = 8'h00;
                if (r_reg.sec >= SEC_ADJ_HALF) begin
                    r_next.min = bcd_inc(r_reg.min);
                    r_next.carry = (r_reg.min == BCD_59);
                end
            end else begin
                r_next.sec = bcd_inc(r_reg.sec);
                if (r_reg.sec == BCD_59) begin
                    r_next.min = bcd_inc(r_reg.min);
                    r_next.carry = (r_reg.min == BCD_59);
                end
            end
            alarm_hit = (r_reg.sec == 8'h00) && (r_reg.min == r_reg.al_min) &&
                        (cur_hour == r_reg.al_hour) && (cur_date == r_reg.al_date) &&
                        (cur_day == r_reg.al_day) && r_reg.page_sel;
        end

        // Counter clear waits for a low-speed edge
        if (pre_clear) begin
            r_next.sec = 8'h00;
            r_next.clr_pend = 1'b0;
            ev[ST_CLR] = 1'b1;
        end

        // Source select
        case ({r_reg.one_hz_disable, r_reg.sixteen_hz_disable, r_reg.alarm_enable})
            3'b111: src = alarm_hit;
            3'b010: src = tick_1hz;
            3'b100: src = tick_16hz;
            default: src = 1'b0;
        endcase
        r_next.src_pulse = src & r_reg.irq_enable;
        ev[ST_SRC] = r_next.src_pulse;

        // Write channel, address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            r_next.aw_full = 1'b1;
            r_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            r_next.w_full = 1'b1;
            r_next.w_data = s_axi_wdata[7:0];
            r_next.w_en = s_axi_wstrb[0];
        end
        if (r_reg.aw_full && r_reg.w_full && !r_reg.bvalid) begin
            r_next.aw_full = 1'b0;
            r_next.w_full = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp = mapped(r_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            wr = r_reg.w_en;
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end

        // Register writes; pending bits only ever set from software
        if (wr) begin
            case (r_reg.aw_addr)
                OFS_MIN: begin
                    if (r_reg.page_sel) begin
                        r_next.al_min = wd;
                    end else begin
                        r_next.min = wd;
                    end
                end
                OFS_HOUR: if (r_reg.page_sel) r_next.al_hour = wd;
                OFS_DATE: if (r_reg.page_sel) r_next.al_date = wd;
                OFS_DAY: if (r_reg.page_sel) r_next.al_day = wd[2:0];
                OFS_PAGE: begin
                    r_next.irq_enable = wd[PG_IRQ_EN];
                    r_next.adjust_pend = r_next.adjust_pend | wd[PG_ADJUST];
                    r_next.clock_run_enable = wd[PG_RUN];
                    r_next.alarm_enable = wd[PG_ALARM];
                    r_next.page_sel = wd[PG_SEL];
                end
                OFS_RESET: begin
                    r_next.one_hz_disable = wd[RS_DIS1];
                    r_next.sixteen_hz_disable = wd[RS_DIS16];
                    r_next.clr_pend = r_next.clr_pend | wd[RS_CLR];
                    r_next.fill = wd[2:0];
                    if (wd[RS_AINIT]) begin
                        r_next.al_min = AL_MIN_INIT;
                        r_next.al_hour = AL_HOUR_INIT;
                        r_next.al_date = AL_DATE_INIT;
                        r_next.al_day = AL_DAY_INIT;
                    end
                end
                OFS_STAT: w1c = wd[2:0];
                OFS_MASK: r_next.mask = wd[2:0];
                default: ;
            endcase
        end

        // Sticky status, a new event beats a same-cycle clear
        r_next.status = (r_reg.status & ~w1c) | ev;

        // Read channel, answer one cycle after the address
        if (s_axi_arvalid && s_axi_arready) begin
            r_next.rvalid = 1'b1;
            r_next.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            r_next.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                OFS_SEC: r_next.rdata[7:0] = r_reg.page_sel ? 8'h00 : r_reg.sec;
                OFS_MIN: r_next.rdata[7:0] = r_reg.page_sel ? r_reg.al_min : r_reg.min;
                OFS_HOUR: r_next.rdata[7:0] = r_reg.page_sel ? r_reg.al_hour : cur_hour;
                OFS_DATE: r_next.rdata[7:0] = r_reg.page_sel ? r_reg.al_date : cur_date;
                OFS_DAY: r_next.rdata[2:0] = r_reg.page_sel ? r_reg.al_day : cur_day;
                OFS_PAGE: r_next.rdata[7:0] = {r_reg.irq_enable, 2'b00, r_reg.adjust_pend,
                                               r_reg.clock_run_enable, r_reg.alarm_enable,
                                               1'b0, r_reg.page_sel};
                OFS_RESET: r_next.rdata[7:0] = {r_reg.one_hz_disable, r_reg.sixteen_hz_disable,
                                                r_reg.clr_pend, 1'b0, 1'b0, r_reg.fill};
                OFS_STAT: r_next.rdata[2:0] = r_reg.status;
                OFS_MASK: r_next.rdata[2:0] = r_reg.mask;
                default: r_next.rdata = 32'h0000_0000;
            endcase
        end else if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= ST_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign s_axi_bvalid = r_reg.bvalid;
    assign s_axi_bresp = r_reg.bresp;
    assign s_axi_rvalid = r_reg.rvalid;
    assign s_axi_rdata = r_reg.rdata;
    assign s_axi_rresp = r_reg.rresp;
    assign minute_carry = r_reg.carry;
    assign rtc_interrupt = r_reg.src_pulse;
    assign irq = |(r_reg.status & r_reg.mask);
endmodule

/* File: hdl/rtcp_prescaler.sv */
`timescale 1ns/1ps
module rtcp_prescaler
    import rtcp_pkg::*;
#(
    parameter int DIV = TICK_1HZ_DIV,
    parameter int SUB = TICK_16HZ_DIV
) (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Low-speed enable and control
    input logic fs_tick,
    input logic clear,
    // Rate ticks
    output logic tick_1hz,
    output logic tick_16hz
);
    localparam int CW = $clog2(DIV);
    localparam int SW = $clog2(SUB);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic t1;
        logic t16;
    } rtcp_pre_t;

    rtcp_pre_t r_reg;
    rtcp_pre_t r_next;

    // ------------------------------------------------------------
    // Free-running divider, only a clear request restarts it
    // ------------------------------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.t1 = 1'b0;
        r_next.t16 = 1'b0;
        if (fs_tick) begin
            if (clear) begin
                r_next.cnt = '0;
            end else begin
                r_next.t1 = (r_reg.cnt == CW'(DIV - 1));
                r_next.t16 = (r_reg.cnt[SW-1:0] == SW'(SUB - 1));
                r_next.cnt = r_next.t1 ? '0 : CW'(r_reg.cnt + 1'b1);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tick_1hz = r_reg.t1;
    assign tick_16hz = r_reg.t16;
endmodule

/* File: pkg/rtcp_pkg.sv */
package rtcp_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SEC = 8'h00;
    localparam logic [7:0] OFS_MIN = 8'h04;
    localparam logic [7:0] OFS_HOUR = 8'h08;
    localparam logic [7:0] OFS_DATE = 8'h0C;
    localparam logic [7:0] OFS_DAY = 8'h10;
    localparam logic [7:0] OFS_PAGE = 8'h1C;
    localparam logic [7:0] OFS_RESET = 8'h20;
    localparam logic [7:0] OFS_STAT = 8'h24;
    localparam logic [7:0] OFS_MASK = 8'h28;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PG_IRQ_EN = 7;
    localparam int PG_ADJUST = 4;
    localparam int PG_RUN = 3;
    localparam int PG_ALARM = 2;
    localparam int PG_SEL = 0;
    localparam int RS_DIS1 = 7;
    localparam int RS_DIS16 = 6;
    localparam int RS_CLR = 5;
    localparam int RS_AINIT = 4;
    localparam int ST_SRC = 0;
    localparam int ST_ADJ = 1;
    localparam int ST_CLR = 2;

    // ------------------------------------------------------------
    // Reset and init values
    // ------------------------------------------------------------
    localparam logic [2:0] RS_FILL_RST = 3'h7;
    localparam logic [7:0] AL_MIN_INIT = 8'h00;
    localparam logic [7:0] AL_HOUR_INIT = 8'h00;
    localparam logic [7:0] AL_DATE_INIT = 8'h01;
    localparam logic [2:0] AL_DAY_INIT = 3'h0;
    localparam logic [7:0] SEC_ADJ_HALF = 8'h30;
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int LS_CLK_HZ = 32768;
    localparam int TICK_1HZ_DIV = LS_CLK_HZ / 1;
    localparam int TICK_16HZ_DIV = LS_CLK_HZ / 16;
endpackage

/* File: tb/rtcp_ctrl_monitor.sv */
`timescale 1ns/1ps
module rtcp_ctrl_monitor
    import rtcp_pkg::*;
#(
    parameter int DIV = TICK_1HZ_DIV,
    parameter int SUB = TICK_16HZ_DIV
) (
    // Clock and reset
    input logic aclk,
    input logic aresetn,
    // Register bus
    input logic s_axi_awready,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [7:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // Timekeeping and events
    input logic low_speed_clk,
    input logic minute_carry,
    input logic rtc_interrupt,
    input logic irq
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic lsc_reg;
    logic [7:0] since_fs_reg;
    logic [7:0] rd_addr_reg;

    // Saturates so long gaps never wrap into a false match
    always_ff @(posedge aclk) begin
        lsc_reg <= low_speed_clk;
        if (!aresetn) begin
            since_fs_reg <= 8'hFF;
        end else if (low_speed_clk && !lsc_reg) begin
            since_fs_reg <= 8'h00;
        end else if (since_fs_reg != 8'hFF) begin
            since_fs_reg <= since_fs_reg + 8'h01;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_reg <= s_axi_araddr;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_int_near_fs;
        rtc_interrupt |-> since_fs_reg <= 8'h04;
    endproperty
    a_int_near_fs: assert property (p_int_near_fs) else $error("interrupt not tied to a slow tick");
    property p_carry_near_fs;
        minute_carry |-> since_fs_reg <= 8'h04;
    endproperty
    a_carry_near_fs: assert property (p_carry_near_fs) else $error("carry not tied to a count-up");
    property p_int_pulse;
        rtc_interrupt |=> !rtc_interrupt;
    endproperty
    a_int_pulse: assert property (p_int_pulse) else $error("interrupt pulse too long");
    property p_carry_pulse;
        minute_carry |=> !minute_carry;
    endproperty
    a_carry_pulse: assert property (p_carry_pulse) else $error("carry pulse too long");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
    property p_wr_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
    property p_wr_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_block: assert property (p_wr_block) else $error("write taken during response");
    property p_page_zero;
        s_axi_rvalid && rd_addr_reg == OFS_PAGE |-> s_axi_rdata[6:5] == 2'h0 && !s_axi_rdata[1];
    endproperty
    a_page_zero: assert property (p_page_zero) else $error("unused page bits set");
    property p_rst_fill;
        s_axi_rvalid && rd_addr_reg == OFS_RESET |-> s_axi_rdata[3:0] == 4'h7;
    endproperty
    a_rst_fill: assert property (p_rst_fill) else $error("reset register low bits wrong");
    property p_irq_fall;
        $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt line fell without a write");

    c_int: cover property (rtc_interrupt);
    c_carry: cover property (minute_carry);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind rtcp_ctrl rtcp_ctrl_monitor #(.DIV(DIV), .SUB(SUB)) u_mon (.*);

/* File: tb/tb_rtcp_ctrl.sv */
`timescale 1ns/1ps
module tb_rtcp_ctrl;
    import rtcp_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic low_speed_clk, minute_carry, rtc_interrupt, irq, fs_on;
    logic [7:0] s_axi_awaddr, s_axi_araddr, cur_hour, cur_date;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] cur_day;
    logic [33:0] exp_r[$];
    logic [33:0] exp_b[$];
    int error_cnt, tests_run, carry_cnt, int_cnt;

    rtcp_ctrl #(.DIV(32), .SUB(2)) dut (.*);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        int n;
        n = 0;
        exp_b.push_back({32'h0000_0000, r});
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid === 1'b1 && s_axi_bready) && n < 64);
        // A hung response counts against the run
        if (n >= 64) error_cnt++;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
        int n;
        n = 0;
        exp_r.push_back({r, 24'h00_0000, d});
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid === 1'b1 && s_axi_rready) && n < 64);
        if (n >= 64) error_cnt++;
        s_axi_rready <= 1'b0;
    endtask

    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        chk("irq", irq, 1);
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clocks, scoreboard and watchdog
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Slow clock can be frozen so a pending clear stays visible
    initial begin
        forever begin
            repeat (8) @(posedge aclk);
            if (fs_on) low_speed_clk <= ~low_speed_clk;
        end
    end

    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready) chk("rdata", {s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
        if (s_axi_bvalid === 1'b1 && s_axi_bready) chk("bresp", {32'h0000_0000, s_axi_bresp}, exp_b.pop_front());
        if (minute_carry === 1'b1) carry_cnt++;
        if (rtc_interrupt === 1'b1) int_cnt++;
    end

    initial begin
        repeat (60000) @(posedge aclk);
        error_cnt++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int c0, e, seed;
        logic [7:0] m;
        seed = $urandom(32'h4f6e_67bc);
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
        s_axi_wstrb = 4'h1;
        low_speed_clk = 1'b0;
        fs_on = 1'b1;
        cur_hour = 8'($urandom_range(35));
        cur_date = 8'($urandom_range(49));
        cur_day = 3'($urandom_range(6));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_PAGE, 8'h00);
        rd(OFS_RESET, 8'hC7);
        rd(8'h2C, 8'h00, RESP_SLVERR);
        wr(8'h2C, 8'hFF, RESP_SLVERR);
        // Write with the low byte lane off must leave the mask alone
        s_axi_wstrb <= 4'h0;
        wr(OFS_MASK, 8'h07);
        s_axi_wstrb <= 4'h1;
        rd(OFS_MASK, 8'h00);
        wr(OFS_PAGE, 8'h62);
        rd(OFS_PAGE, 8'h00);
        wr(OFS_RESET, 8'hCF);
        rd(OFS_RESET, 8'hC7);
        m = {4'($urandom_range(5)), 4'($urandom_range(9))};
        wr(OFS_PAGE, 8'h01);
        wr(OFS_MIN, m);
        rd(OFS_MIN, m);
        wr(OFS_RESET, 8'hD7);
        rd(OFS_MIN, 8'h00);
        rd(OFS_HOUR, 8'h00);
        rd(OFS_DATE, 8'h01);
        rd(OFS_DAY, 8'h00);
        wr(OFS_PAGE, 8'h00);
        rd(OFS_HOUR, cur_hour);
        rd(OFS_MIN, 8'h00);
        wr(OFS_PAGE, 8'h08);
        wr(OFS_MIN, 8'h59);
        repeat (1536) @(posedge aclk);
        wr(OFS_MASK, 8'h04);
        fs_on <= 1'b0;
        wr(OFS_RESET, 8'hE7);
        rd(OFS_RESET, 8'hE7);
        fs_on <= 1'b1;
        wait_irq();
        rd(OFS_SEC, 8'h00);
        rd(OFS_RESET, 8'hC7);
        wr(OFS_STAT, 8'h04);
        repeat (2) @(posedge aclk);
        chk("irq", irq, 0);
        repeat (35 * 512 + 256) @(posedge aclk);
        wr(OFS_MASK, 8'h02);
        wr(OFS_PAGE, 8'h18);
        rd(OFS_PAGE, 8'h18);
        wait_irq();
        rd(OFS_SEC, 8'h00);
        rd(OFS_MIN, 8'h00);
        chk("carry", carry_cnt, 1);
        rd(OFS_PAGE, 8'h08);
        wr(OFS_STAT, 8'h02);
        wr(OFS_PAGE, 8'h00);
        repeat (1792) @(posedge aclk);
        rd(OFS_SEC, 8'h00);
        wr(OFS_PAGE, 8'h18);
        rd(OFS_PAGE, 8'h18);
        wait_irq();
        rd(OFS_SEC, 8'h00);
        rd(OFS_MIN, 8'h00);
        chk("carry", carry_cnt, 1);
        wr(OFS_STAT, 8'h02);
        // Status bit 0 is left masked until the end
        for (int i = 0; i < 8; i++) begin
            e = (i == 2) ? 2 : (i == 4) ? 32 : 0;
            wr(OFS_PAGE, {4'h0, 1'b1, i[0], 2'h0});
            wr(OFS_RESET, {i[2], i[1], 6'h07});
            wr(OFS_PAGE, {4'h8, 1'b1, i[0], 2'h0});
            @(negedge aclk);
            c0 = int_cnt;
            repeat (1024) @(negedge aclk);
            chk("int_cnt", 34'(int_cnt - c0), 34'(e));
            chk("irq", irq, 0);
            wr(OFS_PAGE, {4'h0, 1'b1, i[0], 2'h0});
        end
        // Alarm at the first count-up after a clear, fields from the init values
        {cur_hour, cur_date, cur_day} <= {AL_HOUR_INIT, AL_DATE_INIT, AL_DAY_INIT};
        wr(OFS_PAGE, 8'h0D);
        wr(OFS_RESET, 8'hF7);
        wr(OFS_PAGE, 8'h8D);
        @(negedge aclk);
        c0 = int_cnt;
        repeat (600) @(negedge aclk);
        chk("alarm", 34'(int_cnt - c0), 34'(1));
        wr(OFS_MASK, 8'h01);
        repeat (2) @(posedge aclk);
        chk("irq", irq, 1);
        wr(OFS_STAT, 8'h01);
        repeat (2) @(posedge aclk);
        chk("irq", irq, 0);
        wrap_up();
    end
endmodule
